// [tcsr_regs.sv]
// Tuner control and status register set behind a two-wire serial slave
`timescale 1ns/1ps
`default_nettype none
module tcsr_regs
	import tcsr_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Two-wire serial bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// Status sources
	input wire logic [1:0] i_charge_pump_current_code,
	input wire logic i_autoselect_success,
	input wire logic i_autoselect_idle,
	input wire logic [7:0] i_status_second,
	// Baseband and RF controls
	output logic o_modulation_select,
	output logic o_baseband_gain_step,
	output logic [1:0] o_baseband_bias_level,
	output logic o_injection_side_select,
	output logic [2:0] o_agc_attack_point,
	output logic o_power_detector_enable,
	output logic o_quadrature_channel_on,
	// Power controls
	output logic o_chip_enable,
	output logic o_signal_path_enable,
	output logic o_synth_enable,
	output logic o_crystal_osc_enable,
	output logic o_crystal_out_enable,
	output logic o_crystal_clock_output,
	// Synthesizer words
	output logic [7:0] o_ref_divider,
	output logic [12:0] o_int_divider
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	tcsr_control_t control_r, control_nxt;
	tcsr_xtal_t xtal_r, xtal_nxt;
	logic [7:0] ref_div_r, ref_div_nxt;
	logic [7:0] int_high_r, int_high_nxt;
	logic [4:0] int_low_r, int_low_nxt;
	logic power_cycled_r, power_cycled_nxt;

	// ----------------------------------------------------------------
	// Serial engine state
	// ----------------------------------------------------------------
	tcsr_state_t state_r, state_nxt;
	logic scl_prev_r, scl_prev_nxt;
	logic sda_prev_r, sda_prev_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic read_r, read_nxt;
	logic second_r, second_nxt;
	logic master_ack_r, master_ack_nxt;
	logic pull_low_r, pull_low_nxt;

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic wr_en;
	logic clear_flag;
	tcsr_status_t status_first;

	assign scl_rise = i_scl && !scl_prev_r;
	assign scl_fall = !i_scl && scl_prev_r;
	assign start_cond = i_scl && scl_prev_r && sda_prev_r && !i_sda;
	assign stop_cond = i_scl && scl_prev_r && !sda_prev_r && i_sda;

	// First status byte, unused bits forced low
	always_comb begin
		status_first.unused = TCSR_STATUS_UNUSED;
		status_first.charge_pump_current_code = i_charge_pump_current_code;
		status_first.power_cycled_flag = power_cycled_r;
		status_first.autoselect_success = i_autoselect_success;
		status_first.autoselect_idle = i_autoselect_idle;
	end

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		scl_prev_nxt = i_scl;
		sda_prev_nxt = i_sda;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		read_nxt = read_r;
		second_nxt = second_r;
		master_ack_nxt = master_ack_r;
		pull_low_nxt = pull_low_r;
		wr_en = 1'b0;
		clear_flag = 1'b0;
		if (stop_cond) begin
			clear_flag = read_r;
			state_nxt = TCSR_IDLE;
			read_nxt = 1'b0;
			pull_low_nxt = 1'b0;
		end else if (start_cond) begin
			state_nxt = TCSR_DEV_ADDR;
			cnt_nxt = '0;
			read_nxt = 1'b0;
			pull_low_nxt = 1'b0;
		end else begin
			case (state_r)
				TCSR_DEV_ADDR, TCSR_REG_ADDR, TCSR_WR_DATA: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], i_sda};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == TCSR_BITS_PER_BYTE) begin
						cnt_nxt = '0;
						pull_low_nxt = 1'b1;
						if (state_r == TCSR_DEV_ADDR) begin
							if (shift_r[7:1] == TCSR_SLAVE_ADDR) begin
								read_nxt = shift_r[0];
								state_nxt = TCSR_DEV_ACK;
							end else begin
								pull_low_nxt = 1'b0;
								state_nxt = TCSR_IDLE;
							end
						end else if (state_r == TCSR_REG_ADDR) begin
							ptr_nxt = shift_r;
							state_nxt = TCSR_REG_ACK;
						end else begin
							wr_en = 1'b1;
							state_nxt = TCSR_WR_ACK;
						end
					end
				end
				TCSR_DEV_ACK: begin
					if (scl_fall) begin
						cnt_nxt = '0;
						if (read_r) begin
							shift_nxt = status_first;
							second_nxt = 1'b0;
							pull_low_nxt = !status_first[7];
							state_nxt = TCSR_RD_DATA;
						end else begin
							pull_low_nxt = 1'b0;
							state_nxt = TCSR_REG_ADDR;
						end
					end
				end
				TCSR_REG_ACK: begin
					if (scl_fall) begin
						pull_low_nxt = 1'b0;
						state_nxt = TCSR_WR_DATA;
					end
				end
				TCSR_WR_ACK: begin
					if (scl_fall) begin
						pull_low_nxt = 1'b0;
						ptr_nxt = ptr_r + 8'h01;
						state_nxt = TCSR_WR_DATA;
					end
				end
				TCSR_RD_DATA: begin
					if (scl_rise) begin
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (cnt_r == TCSR_BITS_PER_BYTE) begin
							cnt_nxt = '0;
							pull_low_nxt = 1'b0;
							state_nxt = TCSR_RD_ACK;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b0};
							pull_low_nxt = !shift_r[6];
						end
					end
				end
				TCSR_RD_ACK: begin
					if (scl_rise) begin
						master_ack_nxt = !i_sda;
					end else if (scl_fall) begin
						if (master_ack_r) begin
							second_nxt = !second_r;
							shift_nxt = second_r ? status_first : i_status_second;
							pull_low_nxt = second_r ? !status_first[7] : !i_status_second[7];
							state_nxt = TCSR_RD_DATA;
						end else begin
							state_nxt = TCSR_IDLE;
						end
					end
				end
				default: begin
					pull_low_nxt = 1'b0;
					state_nxt = TCSR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= TCSR_IDLE;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
			cnt_r <= '0;
			shift_r <= '0;
			ptr_r <= '0;
			read_r <= 1'b0;
			second_r <= 1'b0;
			master_ack_r <= 1'b0;
			pull_low_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			scl_prev_r <= scl_prev_nxt;
			sda_prev_r <= sda_prev_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			read_r <= read_nxt;
			second_r <= second_nxt;
			master_ack_r <= master_ack_nxt;
			pull_low_r <= pull_low_nxt;
		end
	end

	// Open-drain: only ever drive low
	assign o_sda_out = 1'b0;
	assign o_sda_oe_n = !pull_low_r;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_comb begin
		control_nxt = control_r;
		xtal_nxt = xtal_r;
		ref_div_nxt = ref_div_r;
		int_high_nxt = int_high_r;
		int_low_nxt = int_low_r;
		power_cycled_nxt = power_cycled_r;
		if (clear_flag) begin
			power_cycled_nxt = 1'b0;
		end
		if (wr_en) begin
			if (ptr_r == TCSR_ADDR_CONTROL) begin
				control_nxt = shift_r;
			end else if (ptr_r == TCSR_ADDR_XTAL_DIV) begin
				xtal_nxt = shift_r;
			end else if (ptr_r == TCSR_ADDR_REF_DIV) begin
				ref_div_nxt = shift_r;
			end else if (ptr_r == TCSR_ADDR_INT_DIV_HIGH) begin
				int_high_nxt = shift_r;
			end else if (ptr_r == TCSR_ADDR_INT_DIV_LOW) begin
				int_low_nxt = shift_r[7:TCSR_INT_LOW_LSB];
			end
		end
	end

	// Power-cycled flag comes up set on every reset
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			control_r <= TCSR_RST_CONTROL;
			xtal_r <= TCSR_RST_XTAL_DIV;
			ref_div_r <= TCSR_RST_REF_DIV;
			int_high_r <= TCSR_RST_INT_DIV_HIGH;
			int_low_r <= TCSR_RST_INT_DIV_LOW;
			power_cycled_r <= 1'b1;
		end else begin
			control_r <= control_nxt;
			xtal_r <= xtal_nxt;
			ref_div_r <= ref_div_nxt;
			int_high_r <= int_high_nxt;
			int_low_r <= int_low_nxt;
			power_cycled_r <= power_cycled_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Control decode
	// ----------------------------------------------------------------
	logic path_on;
	assign path_on = !xtal_r.soft_power_down && !xtal_r.soft_standby;

	assign o_modulation_select = control_r.modulation_select;
	assign o_baseband_gain_step = control_r.modulation_select && path_on;
	assign o_baseband_bias_level = control_r.baseband_bias_level;
	assign o_injection_side_select = control_r.injection_side_select;
	assign o_agc_attack_point = control_r.agc_attack_point;
	assign o_power_detector_enable = control_r.power_detector_enable && path_on;
	assign o_quadrature_channel_on = !xtal_r.quadrature_channel_off && path_on;
	assign o_chip_enable = !xtal_r.soft_power_down;
	assign o_signal_path_enable = path_on;
	assign o_synth_enable = path_on;
	assign o_crystal_osc_enable = !xtal_r.soft_power_down;
	assign o_crystal_out_enable = !xtal_r.soft_power_down
		&& xtal_r.crystal_out_divider != 5'h00;
	assign o_ref_divider = ref_div_r;
	assign o_int_divider = {int_high_r, int_low_r};

	tcsr_xtal_div #(
		.WIDTH(5)
	) u_xtal_div (
		.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n),
		.i_enable(o_crystal_out_enable),
		.i_ratio(xtal_r.crystal_out_divider),
		.o_tick(o_crystal_clock_output)
	);

endmodule
`default_nettype wire

// [tcsr_pkg.sv]
// Package of constants and types for the tuner control and status register set
// Function
// - Modulation bit selects QAM or QPSK plus 7dB
// - Bias bits 6:5 select baseband linearity level
// - Bit 4 selects low or high LO injection
// - Bits 3:1 set AGC attack point, 2dB steps
// - Bit 0 enables the power detector
// - Crystal divider code: zero off, else divide-by-code
// - Power-down stops chip, bus and registers kept
// - Standby stops path and synth, crystal stays
// - Bit 0 high disables Q channel output
// - Reference divider byte, default 56, range 22-182
// - Integer divider split: high byte, low bits 7:3
// - Status bits 4:3 mirror charge-pump code, 7:5 zero
// - Status bit 2 high after power cycle
// - STOP during read clears the power-cycled flag
// - Status bit 1 reports autoselect success
// - Status bit 0 high while autoselect inactive
// - Read returns status one then two, MSB first
// - Write data bytes go to successive register addresses
// - Charge-pump code maps 1.5, 2, 2.5, 3 mA
package tcsr_pkg;

	// ----------------------------------------------------------------
	// Serial bus
	// ----------------------------------------------------------------
	localparam logic [6:0] TCSR_SLAVE_ADDR = 7'h60;
	localparam logic [3:0] TCSR_BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] TCSR_ADDR_INT_DIV_HIGH = 8'h00;
	localparam logic [7:0] TCSR_ADDR_INT_DIV_LOW = 8'h01;
	localparam logic [7:0] TCSR_ADDR_REF_DIV = 8'h02;
	localparam logic [7:0] TCSR_ADDR_CONTROL = 8'h03;
	localparam logic [7:0] TCSR_ADDR_XTAL_DIV = 8'h04;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] TCSR_RST_CONTROL = 8'h56;
	localparam logic [7:0] TCSR_RST_XTAL_DIV = 8'h08;
	localparam logic [7:0] TCSR_RST_REF_DIV = 8'h38;
	localparam logic [7:0] TCSR_RST_INT_DIV_HIGH = 8'h53;
	localparam logic [4:0] TCSR_RST_INT_DIV_LOW = 5'h1f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TCSR_INT_LOW_LSB = 3;
	localparam logic [1:0] TCSR_STATUS_PAD = 2'h0;
	localparam logic [2:0] TCSR_STATUS_UNUSED = 3'h0;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic modulation_select;
		logic [1:0] baseband_bias_level;
		logic injection_side_select;
		logic [2:0] agc_attack_point;
		logic power_detector_enable;
	} tcsr_control_t;

	typedef struct packed {
		logic [4:0] crystal_out_divider;
		logic soft_power_down;
		logic soft_standby;
		logic quadrature_channel_off;
	} tcsr_xtal_t;

	typedef struct packed {
		logic [2:0] unused;
		logic [1:0] charge_pump_current_code;
		logic power_cycled_flag;
		logic autoselect_success;
		logic autoselect_idle;
	} tcsr_status_t;

	// Serial engine states
	typedef enum logic [3:0] {
		TCSR_IDLE = 4'h0,
		TCSR_DEV_ADDR = 4'h1,
		TCSR_DEV_ACK = 4'h2,
		TCSR_REG_ADDR = 4'h3,
		TCSR_REG_ACK = 4'h4,
		TCSR_WR_DATA = 4'h5,
		TCSR_WR_ACK = 4'h6,
		TCSR_RD_DATA = 4'h7,
		TCSR_RD_ACK = 4'h8
	} tcsr_state_t;

endpackage

// [tcsr_xtal_div.sv]
// Crystal output divider producing one enable pulse per divide period
`timescale 1ns/1ps
`default_nettype none
module tcsr_xtal_div #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Control
	input wire logic i_enable,
	input wire logic [WIDTH-1:0] i_ratio,
	// Divided output
	output logic o_tick
);

	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	// Code zero turns the output off; other codes divide by the code
	always_comb begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (!i_enable || i_ratio == '0) begin
			cnt_nxt = '0;
		end else if (cnt_r + 1'b1 >= i_ratio) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;

endmodule
`default_nettype wire

// [tcsr_regs_checker.sv]
// Port-level checker for the tuner register set
`timescale 1ns/1ps
`default_nettype none
module tcsr_regs_checker (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Watched ports
	input wire logic i_scl,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic o_modulation_select,
	input wire logic o_baseband_gain_step,
	input wire logic o_power_detector_enable,
	input wire logic o_quadrature_channel_on,
	input wire logic o_chip_enable,
	input wire logic o_signal_path_enable,
	input wire logic o_synth_enable,
	input wire logic o_crystal_osc_enable,
	input wire logic o_crystal_out_enable,
	input wire logic o_crystal_clock_output,
	input wire logic [7:0] o_ref_divider,
	input wire logic [12:0] o_int_divider
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_arst_n);
	// ----
	// Assertions
	// ----
	a_gain_step: assert property (
		o_baseband_gain_step == (o_modulation_select && o_signal_path_enable))
		else $error("gain step wrong");
	a_detector_gate: assert property (o_power_detector_enable |-> o_signal_path_enable)
		else $error("detector on without path");
	a_q_gate: assert property (o_quadrature_channel_on |-> o_signal_path_enable)
		else $error("q channel on without path");
	a_power_down: assert property (!o_chip_enable |-> !(o_signal_path_enable ||
		o_synth_enable || o_crystal_osc_enable || o_crystal_out_enable))
		else $error("power-down left a block on");
	a_standby_pair: assert property ((o_signal_path_enable == o_synth_enable) &&
		(o_chip_enable || !o_signal_path_enable))
		else $error("standby split");
	a_xtal_off: assert property (!o_crystal_out_enable [*2] |-> !o_crystal_clock_output)
		else $error("crystal pulse while off");
	a_reg_update: assert property (
		!$stable({o_ref_divider, o_int_divider}) |-> !i_scl && !$past(i_scl))
		else $error("register changed outside bus low phase");
	a_sda_change: assert property (!$stable(o_sda_oe_n) |-> !i_scl)
		else $error("data moved while clock high");
	a_sda_hold: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*4])
		else $error("data pull too short");
	a_sda_value: assert property (o_sda_out == 1'b0)
		else $error("open-drain value not low");
	c_write: cover property (!$stable(o_ref_divider));
	c_pull: cover property ($fell(o_sda_oe_n));
	c_standby: cover property (o_chip_enable && !o_signal_path_enable);
endmodule
bind tcsr_regs tcsr_regs_checker tcsr_regs_checker_i (.i_core_clk(i_core_clk),
	.i_arst_n(i_arst_n), .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
	.o_modulation_select(o_modulation_select), .o_baseband_gain_step(o_baseband_gain_step),
	.o_power_detector_enable(o_power_detector_enable),
	.o_quadrature_channel_on(o_quadrature_channel_on), .o_chip_enable(o_chip_enable),
	.o_signal_path_enable(o_signal_path_enable), .o_synth_enable(o_synth_enable),
	.o_crystal_osc_enable(o_crystal_osc_enable), .o_crystal_out_enable(o_crystal_out_enable),
	.o_crystal_clock_output(o_crystal_clock_output), .o_ref_divider(o_ref_divider),
	.o_int_divider(o_int_divider));
`default_nettype wire

// [tcsr_host.sv]
// Two-wire bus master model driving the register set
`timescale 1ns/1ps
`default_nettype none
module tcsr_host (
	// Clock
	input wire logic i_clk,
	// Bus lines
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic start();
		q(4);
		o_sda_low = 1'b1;
		q(4);
		o_scl = 1'b0;
	endtask
	task automatic stop();
		q(1);
		o_sda_low = 1'b1;
		q(3);
		o_scl = 1'b1;
		q(4);
		o_sda_low = 1'b0;
		q(4);
	endtask
	// Data moves only while the clock is low; sampled mid high phase
	task automatic bitx(input logic b, output logic r);
		q(1);
		o_sda_low = !b;
		q(3);
		o_scl = 1'b1;
		q(2);
		r = i_sda;
		q(2);
		o_scl = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r,
		output logic s_ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(m_ack, s_ack);
	endtask
endmodule
`default_nettype wire

// [tb_tuner_control_status_regs.sv]
// Self-checking bench for the tuner control and status register set
`timescale 1ns/1ps
`default_nettype none
module tb_tuner_control_status_regs import tcsr_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] pump = 2'h2;
	logic succ = 1'b1;
	logic idle = 1'b0;
	logic [7:0] st2 = 8'h5a;
	int n_errors = 0;
	int checks_done = 0;
	wire logic scl, sda_low, sda_out, sda_oe_n, sda;
	wire logic msel, gain, inj, pde, qon, chip, path, synth, osc, xout, xclk;
	wire logic [1:0] bias;
	wire logic [2:0] agc;
	wire logic [7:0] refd;
	wire logic [12:0] intd;
	// Open-drain line with pull-up
	assign sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
	always #25 clk = ~clk;
	tcsr_host tcsr_host_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	tcsr_regs tcsr_regs_i (.i_core_clk(clk), .i_arst_n(rst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_charge_pump_current_code(pump),
		.i_autoselect_success(succ), .i_autoselect_idle(idle), .i_status_second(st2),
		.o_modulation_select(msel), .o_baseband_gain_step(gain), .o_baseband_bias_level(bias),
		.o_injection_side_select(inj), .o_agc_attack_point(agc),
		.o_power_detector_enable(pde), .o_quadrature_channel_on(qon), .o_chip_enable(chip),
		.o_signal_path_enable(path), .o_synth_enable(synth), .o_crystal_osc_enable(osc),
		.o_crystal_out_enable(xout), .o_crystal_clock_output(xclk), .o_ref_divider(refd),
		.o_int_divider(intd));
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic k;
		tcsr_host_i.start();
		tcsr_host_i.xfer({TCSR_SLAVE_ADDR, 1'b0}, 1'b1, r, k);
		tcsr_host_i.xfer(a, 1'b1, r, k);
		tcsr_host_i.xfer(d, 1'b1, r, k);
		check(k, 1'b0);
		tcsr_host_i.stop();
	endtask
	task automatic rd1(output logic [7:0] r);
		logic k;
		tcsr_host_i.start();
		tcsr_host_i.xfer({TCSR_SLAVE_ADDR, 1'b1}, 1'b1, r, k);
		tcsr_host_i.xfer(8'hff, 1'b1, r, k);
		tcsr_host_i.stop();
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		check({msel, bias, inj, agc, pde}, 8'h56);
		check(gain, 1'b0);
		check({chip, path, synth, osc, xout, qon}, 6'h3f);
		check(refd, 8'h38);
		check(intd, 13'h0a7f);
	endtask
	task automatic t_burst();
		logic [7:0] d [5] = '{8'h29, 8'hab, 8'hb6, 8'he1, 8'h19};
		logic [7:0] r;
		logic k;
		tcsr_host_i.start();
		tcsr_host_i.xfer({TCSR_SLAVE_ADDR, 1'b0}, 1'b1, r, k);
		tcsr_host_i.xfer(TCSR_ADDR_INT_DIV_HIGH, 1'b1, r, k);
		foreach (d[j]) begin
			tcsr_host_i.xfer(d[j], 1'b1, r, k);
			check(k, 1'b0);
		end
		tcsr_host_i.stop();
		check(intd, 13'h0535);
		check(refd, 8'hb6);
		check({msel, gain, bias, inj, agc, pde, qon}, 10'h3c2);
		for (int c = 0; c < 8; c++) begin
			wr(TCSR_ADDR_CONTROL, {1'b1, c[1:0], c[0], c[2:0], 1'b1});
			check({bias, inj, agc}, {c[1:0], c[0], c[2:0]});
		end
	endtask
	task automatic t_xtal();
		logic [4:0] dv [4] = '{5'h00, 5'h01, 5'h03, 5'h1f};
		int n;
		foreach (dv[j]) begin
			wr(TCSR_ADDR_XTAL_DIV, {dv[j], 3'h0});
			tcsr_host_i.q(40);
			n = 0;
			repeat (186) begin
				tcsr_host_i.q(1);
				if (xclk === 1'b1) begin
					n++;
				end
			end
			check(n[15:0], 16'(dv[j] == 0 ? 0 : 186 / dv[j]));
			check(xout, dv[j] != 5'h00);
		end
	endtask
	task automatic t_power();
		wr(TCSR_ADDR_XTAL_DIV, 8'h1a);
		check({chip, path, synth, osc, xout, qon, pde, gain}, 8'h98);
		check(msel, 1'b1);
		wr(TCSR_ADDR_XTAL_DIV, 8'h1c);
		check({chip, path, synth, osc, xout, qon, pde, gain}, 8'h00);
		check({msel, refd}, 9'h1b6);
		wr(TCSR_ADDR_XTAL_DIV, 8'h19);
		check({chip, path, synth, osc, xout, qon, pde, gain}, 8'hfb);
		wr(TCSR_ADDR_XTAL_DIV, 8'h18);
		check(qon, 1'b1);
	endtask
	task automatic t_refuse();
		logic [7:0] r;
		logic k;
		tcsr_host_i.start();
		tcsr_host_i.xfer({TCSR_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, r, k);
		check(k, 1'b1);
		tcsr_host_i.xfer(TCSR_ADDR_REF_DIV, 1'b1, r, k);
		tcsr_host_i.xfer(8'h16, 1'b1, r, k);
		tcsr_host_i.stop();
		wr(8'h07, 8'h00);
		check({refd, intd[7:0]}, 16'hb635);
	endtask
	task automatic t_status();
		logic [7:0] r;
		logic k;
		tcsr_host_i.start();
		tcsr_host_i.xfer({TCSR_SLAVE_ADDR, 1'b1}, 1'b1, r, k);
		check(k, 1'b0);
		tcsr_host_i.xfer(8'hff, 1'b0, r, k);
		check(r, 8'h16);
		tcsr_host_i.xfer(8'hff, 1'b1, r, k);
		check(r, st2);
		tcsr_host_i.stop();
		pump = 2'h1;
		succ = 1'b0;
		idle = 1'b1;
		rd1(r);
		check(r, 8'h09);
		rst_n = 1'b0;
		tcsr_host_i.q(2);
		rst_n = 1'b1;
		check(refd, 8'h38);
		rd1(r);
		check(r, 8'h0d);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_burst();
		t_xtal();
		t_power();
		t_refuse();
		t_status();
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
